// [core/swcd_defines.svh]
// Offsets, field positions, reset values and timing counts of the switch configuration decode
// Overview of operation
// R1: Dual mode ignores code top bit; low pair A/B, high pair C/D, channel n.
// R2: Single mode uses full 4-bit code to pick one of sixteen channels.
// R3: Termination enable cleared disconnects all input terminations, whatever the pulse bits.
// R4: Termination enable set connects inputs; only pulse bits may briefly disconnect.
// R5: Pulse bit set disconnects that channel 100 ms on every source switch.
// R6: Pulse bit cleared keeps that channel connected across source switches.
// R7: Pulse bits 0-3 B0-B3, 4-7 A0-A3, 8-11 C3-C0, 12-15 D3-D0.
// R8: Equalizer bits share that mapping; clear is 6 dB, set is 12 dB.
// R9: One 2-bit pre-emphasis code for all outputs: 0, 2, 4, 6 dB.
// R10: First byte covers sources A and B, second byte sources C and D.
// R11: Own-clock counter times disconnect; new switch restarts it; idle after reset.
`ifndef SWCD_DEFINES_SVH
`define SWCD_DEFINES_SVH

`define SWCD_ADDR_W 8
`define SWCD_OFS_RX_SET 8'h00
`define SWCD_OFS_PT_LO 8'h04
`define SWCD_OFS_PT_HI 8'h08
`define SWCD_OFS_EQ_LO 8'h0C
`define SWCD_OFS_EQ_HI 8'h10
`define SWCD_OFS_TX_SET 8'h14
`define SWCD_OFS_AUX_CTL 8'h18
`define SWCD_OFS_SRC_SEL 8'h1C
`define SWCD_OFS_STATUS 8'h20

`define SWCD_RX_TERM_BIT 0
`define SWCD_OUTPUT_PREEMPH_LEVEL_LSB 2
`define SWCD_AUX_MODE_BIT 4

`define SWCD_RST_RX_SET 8'h01
`define SWCD_RST_BYTE 8'h00
`define SWCD_RST_SRC 2'h0

`define SWCD_RESP_OKAY 2'h0
`define SWCD_RESP_SLVERR 2'h2

`define SWCD_CLK_HZ 10000000
`define SWCD_PULSE_MS 100
`define SWCD_PULSE_CYC (`SWCD_PULSE_MS * (`SWCD_CLK_HZ / 1000))

`endif

// [core/swcd_pkg.sv]
// Types shared by the switch configuration decode
package swcd_pkg;

  typedef enum logic {SWCD_BUNDLE_DUAL, SWCD_BUNDLE_SINGLE} swcd_bundle_e;

  // Auxiliary routing: natural channel index is source*4 + channel
  typedef struct packed {
    logic [3:0] high_sel;
    logic [3:0] low_sel;
  } swcd_aux_s;

endpackage : swcd_pkg

// [core/swcd_top.sv]
// Switch configuration decode with AXI4-Lite register access
//
// Our own choices: the AXI4-Lite slave port and the address map.
`include "swcd_defines.svh"

module swcd_top #(
  parameter int unsigned PULSE_CYCLES = `SWCD_PULSE_CYC
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // AXI4-Lite write channels
  input wire logic [`SWCD_ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // AXI4-Lite read channels
  input wire logic [`SWCD_ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Analog controls, natural channel index source*4 + channel
  output logic [15:0] term_connected_o,
  output logic [15:0] input_eq_level_o,
  output logic [1:0] output_preemph_level_o,
  output logic [1:0] hs_source_o,
  output swcd_pkg::swcd_aux_s aux_common_output_o,
  output logic aux_single_mode_o
);
  import swcd_pkg::*;

  localparam int CW = $clog2(PULSE_CYCLES + 1);

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0] rx_set_reg, pt_lo_reg, pt_hi_reg, eq_lo_reg, eq_hi_reg, tx_set_reg, aux_ctl_reg;
  logic [1:0] src_reg, pe_reg, src_out_reg;
  logic busy_reg, single_reg, chk_live_reg;
  logic [CW-1:0] cnt_reg;
  logic [15:0] term_reg, eq_reg;
  swcd_aux_s aux_reg;
  // Bus state
  logic awready_reg, wready_reg, aw_hold_reg, w_hold_reg, bvalid_reg, arready_reg, rvalid_reg;
  logic [`SWCD_ADDR_W-1:0] aw_addr_reg;
  logic [31:0] w_data_reg, rdata_reg;
  logic [3:0] w_strb_reg;
  logic [1:0] bresp_reg, rresp_reg;
  // Decode nets
  logic do_write, wr_lane0, wr_mapped, sw_evt, rd_mapped;
  logic [31:0] rd_word;
  logic [15:0] pulse_vec, eq_vec, term_next, eq_next;
  swcd_aux_s aux_next;

  ////////////////////////////////////////////////////////////////////////////
  // Write channels: address and data taken in either order, response after both
  assign do_write = aw_hold_reg && w_hold_reg && !bvalid_reg;
  assign wr_lane0 = do_write && w_strb_reg[0];
  // Every word-aligned offset up to the status word is mapped
  assign wr_mapped = (aw_addr_reg <= `SWCD_OFS_STATUS) && (aw_addr_reg[1:0] == 2'b00);
  always_ff @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      awready_reg <= 1'b0;
      aw_hold_reg <= 1'b0;
      aw_addr_reg <= '0;
    end
    else if (s_axi_awvalid_i && awready_reg)
    begin
      awready_reg <= 1'b0;
      aw_hold_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr_i;
    end
    else if (do_write)
      aw_hold_reg <= 1'b0;
    else if (!aw_hold_reg && !bvalid_reg)
      awready_reg <= 1'b1;
  end
  always_ff @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      wready_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
    end
    else if (s_axi_wvalid_i && wready_reg)
    begin
      wready_reg <= 1'b0;
      w_hold_reg <= 1'b1;
      w_data_reg <= s_axi_wdata_i;
      w_strb_reg <= s_axi_wstrb_i;
    end
    else if (do_write)
      w_hold_reg <= 1'b0;
    else if (!w_hold_reg && !bvalid_reg)
      wready_reg <= 1'b1;
  end
  always_ff @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      bvalid_reg <= 1'b0;
      bresp_reg <= `SWCD_RESP_OKAY;
    end
    else if (do_write)
    begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_mapped ? `SWCD_RESP_OKAY : `SWCD_RESP_SLVERR;
    end
    else if (bvalid_reg && s_axi_bready_i)
      bvalid_reg <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes; byte lane 0 carries each 8-bit register
  always_ff @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      rx_set_reg <= `SWCD_RST_RX_SET;
      pt_lo_reg <= `SWCD_RST_BYTE;
      pt_hi_reg <= `SWCD_RST_BYTE;
      eq_lo_reg <= `SWCD_RST_BYTE;
      eq_hi_reg <= `SWCD_RST_BYTE;
      tx_set_reg <= `SWCD_RST_BYTE;
      aux_ctl_reg <= `SWCD_RST_BYTE;
      src_reg <= `SWCD_RST_SRC;
    end
    else if (wr_lane0)
    begin
      unique case (aw_addr_reg)
        `SWCD_OFS_RX_SET: rx_set_reg <= w_data_reg[7:0];
        `SWCD_OFS_PT_LO: pt_lo_reg <= w_data_reg[7:0]; // R10
        `SWCD_OFS_PT_HI: pt_hi_reg <= w_data_reg[7:0]; // R10
        `SWCD_OFS_EQ_LO: eq_lo_reg <= w_data_reg[7:0]; // R10
        `SWCD_OFS_EQ_HI: eq_hi_reg <= w_data_reg[7:0]; // R10
        `SWCD_OFS_TX_SET: tx_set_reg <= w_data_reg[7:0];
        `SWCD_OFS_AUX_CTL: aux_ctl_reg <= w_data_reg[7:0];
        `SWCD_OFS_SRC_SEL: src_reg <= w_data_reg[1:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Disconnect interval; a rewrite of the same source is not a switch
  assign sw_evt = wr_lane0 && (aw_addr_reg == `SWCD_OFS_SRC_SEL)
    && (w_data_reg[1:0] != src_reg);
  always_ff @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      busy_reg <= 1'b0; // R11
      cnt_reg <= '0;
    end
    else if (sw_evt)
    begin
      busy_reg <= 1'b1; // R11
      cnt_reg <= '0;
    end
    else if (busy_reg)
    begin
      if (cnt_reg == CW'(PULSE_CYCLES - 1))
      begin
        busy_reg <= 1'b0; // R5
        cnt_reg <= '0;
      end
      else
        cnt_reg <= cnt_reg + CW'(1); // R11
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel decode from register bit order to natural channel order
  assign pulse_vec = {pt_hi_reg, pt_lo_reg};
  assign eq_vec = {eq_hi_reg, eq_lo_reg};
  for (genvar i = 0; i < 16; i++)
  begin : g_chan
    localparam int SRC = i / 4;
    localparam int N = i % 4;
    localparam int BITX = (SRC == 0) ? 4 + N : (SRC == 1) ? N : (SRC == 2) ? 11 - N : 15 - N; // R7
    assign term_next[i] = rx_set_reg[`SWCD_RX_TERM_BIT] // R3
      && !(pulse_vec[BITX] && busy_reg); // R4 R5 R6
    assign eq_next[i] = eq_vec[BITX]; // R8
  end

  // Dual mode drops the top code bit, so A/B share the low pair and C/D the high
  always_comb
  begin
    if (aux_ctl_reg[`SWCD_AUX_MODE_BIT] == SWCD_BUNDLE_SINGLE)
    begin
      aux_next.low_sel = aux_ctl_reg[3:0]; // R2
      aux_next.high_sel = aux_ctl_reg[3:0]; // R2
    end
    else
    begin
      aux_next.low_sel = {1'b0, aux_ctl_reg[2:0]}; // R1
      aux_next.high_sel = {1'b1, aux_ctl_reg[2:0]}; // R1
    end
  end
  always_ff @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      term_reg <= 16'h0000;
      eq_reg <= 16'h0000;
      pe_reg <= 2'h0;
      src_out_reg <= `SWCD_RST_SRC;
      aux_reg <= '0;
      single_reg <= 1'b0;
    end
    else
    begin
      term_reg <= term_next;
      eq_reg <= eq_next;
      pe_reg <= tx_set_reg[`SWCD_OUTPUT_PREEMPH_LEVEL_LSB +: 2]; // R9
      src_out_reg <= src_reg;
      aux_reg <= aux_next;
      single_reg <= aux_ctl_reg[`SWCD_AUX_MODE_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel; status shows live termination state and the interval
  always_comb
  begin
    rd_mapped = 1'b1;
    rd_word = 32'h0000_0000;
    unique case (s_axi_araddr_i)
      `SWCD_OFS_RX_SET: rd_word[7:0] = rx_set_reg;
      `SWCD_OFS_PT_LO: rd_word[7:0] = pt_lo_reg;
      `SWCD_OFS_PT_HI: rd_word[7:0] = pt_hi_reg;
      `SWCD_OFS_EQ_LO: rd_word[7:0] = eq_lo_reg;
      `SWCD_OFS_EQ_HI: rd_word[7:0] = eq_hi_reg;
      `SWCD_OFS_TX_SET: rd_word[7:0] = tx_set_reg;
      `SWCD_OFS_AUX_CTL: rd_word[7:0] = aux_ctl_reg;
      `SWCD_OFS_SRC_SEL: rd_word[1:0] = src_reg;
      `SWCD_OFS_STATUS: rd_word[16:0] = {busy_reg, term_reg};
      default: rd_mapped = 1'b0;
    endcase
  end
  always_ff @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= `SWCD_RESP_OKAY;
    end
    else if (s_axi_arvalid_i && arready_reg)
    begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_word;
      rresp_reg <= rd_mapped ? `SWCD_RESP_OKAY : `SWCD_RESP_SLVERR;
    end
    else if (rvalid_reg && s_axi_rready_i)
      rvalid_reg <= 1'b0;
    else if (!rvalid_reg)
      arready_reg <= 1'b1;
  end

  assign s_axi_awready_o = awready_reg;
  assign s_axi_wready_o = wready_reg;
  assign s_axi_bvalid_o = bvalid_reg;
  assign s_axi_bresp_o = bresp_reg;
  assign s_axi_arready_o = arready_reg;
  assign s_axi_rvalid_o = rvalid_reg;
  assign s_axi_rdata_o = rdata_reg;
  assign s_axi_rresp_o = rresp_reg;
  assign term_connected_o = term_reg;
  assign input_eq_level_o = eq_reg;
  assign output_preemph_level_o = pe_reg;
  assign hs_source_o = src_out_reg;
  assign aux_common_output_o = aux_reg;
  assign aux_single_mode_o = single_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks, armed one edge after reset: output reset values lag the registers
  always_ff @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
      chk_live_reg <= 1'b0;
    else
      chk_live_reg <= 1'b1;
  end
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (reset_i || !chk_live_reg);
  a_dual_aux_route: assert property ( // R1
    (aux_ctl_reg[`SWCD_AUX_MODE_BIT] == 1'b0) |=> (aux_common_output_o.low_sel
      == {1'b0, $past(aux_ctl_reg[2:0])}) && (aux_common_output_o.high_sel
      == {1'b1, $past(aux_ctl_reg[2:0])}))
    else $error("dual mode aux route wrong");
  a_single_aux_route: assert property ( // R2
    aux_ctl_reg[`SWCD_AUX_MODE_BIT] |=> aux_common_output_o.low_sel
      == $past(aux_ctl_reg[3:0]) && aux_common_output_o.high_sel
      == $past(aux_ctl_reg[3:0]) && aux_single_mode_o)
    else $error("single mode aux route wrong");
  a_term_all_off: assert property ( // R3
    !rx_set_reg[`SWCD_RX_TERM_BIT] |=> term_connected_o == 16'h0000)
    else $error("termination not off while disabled");
  a_term_idle_on: assert property ( // R4
    rx_set_reg[`SWCD_RX_TERM_BIT] && !busy_reg |=> term_connected_o == 16'hFFFF)
    else $error("termination not on while enabled and idle");
  a_pulse_length: assert property ( // R5
    busy_reg && !sw_evt |=> (busy_reg && cnt_reg == $past(cnt_reg) + 1)
      || (!busy_reg && $past(cnt_reg) == PULSE_CYCLES - 1))
    else $error("disconnect interval miscounted");
  a_no_pulse_kept: assert property ( // R6
    rx_set_reg[`SWCD_RX_TERM_BIT] && pulse_vec == 16'h0000 && sw_evt
      |=> term_connected_o == 16'hFFFF [*2])
    else $error("termination dropped without pulse bit");
  a_pulse_bit_map: assert property ( // R7
    busy_reg && rx_set_reg[`SWCD_RX_TERM_BIT] && pulse_vec[0] && pulse_vec[8]
      |=> !term_connected_o[4] && !term_connected_o[11])
    else $error("pulse bit mapped to wrong channel");
  a_eq_bit_map: assert property ( // R8
    ##1 input_eq_level_o[0] == $past(eq_lo_reg[4])
      && input_eq_level_o[12] == $past(eq_hi_reg[7]))
    else $error("equalizer bit mapped to wrong channel");
  a_preemph_code: assert property ( // R9
    ##1 output_preemph_level_o == $past(tx_set_reg[3:2]))
    else $error("pre-emphasis code not applied");
  a_switch_restart: assert property ( // R11
    sw_evt |=> busy_reg && cnt_reg == '0)
    else $error("source switch did not restart interval");
endmodule : swcd_top

// [tb/swcd_top_tb_top.sv]
// Register-level testbench for the switch configuration decode
`include "swcd_defines.svh"

module swcd_top_tb_top;
  import swcd_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  // Short pulse count keeps the run small; expectations derive from it
  localparam int unsigned PC = 20;

  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  logic [7:0] awaddr = 8'h00;
  logic awvalid = 1'b0;
  logic awready;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h0;
  logic wvalid = 1'b0;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready = 1'b0;
  logic [7:0] araddr = 8'h00;
  logic arvalid = 1'b0;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready = 1'b0;
  logic [15:0] term;
  logic [15:0] eq;
  logic [1:0] pe;
  logic [1:0] hs_src;
  swcd_aux_s aux;
  logic single;
  int errors = 0;
  int check_count = 0;
  logic [1:0] resp;
  logic [31:0] rd;

  always #50 clk_sys_i = ~clk_sys_i;

  swcd_top #(.PULSE_CYCLES(PC)) DUT (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .term_connected_o(term),
    .input_eq_level_o(eq), .output_preemph_level_o(pe), .hs_source_o(hs_src),
    .aux_common_output_o(aux), .aux_single_mode_o(single)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    if (errors == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_of_test

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask : cyc

  // Bready stays high from the start; the slave must answer within 50 cycles
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [1:0] r);
    int n;
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge clk_sys_i);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1)
      begin
        r = bresp;
        break;
      end
    end
    bready <= 1'b0;
    if (n == 50)
    begin
      errors++;
      end_of_test();
    end
    @(posedge clk_sys_i);
  endtask : wr

  task automatic w8(input logic [7:0] a, input logic [7:0] d);
    logic [1:0] r;
    wr(a, {24'h00_0000, d}, 4'h1, r);
    check("bresp", {30'h0, r}, {30'h0, `SWCD_RESP_OKAY});
  endtask : w8

  task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge clk_sys_i);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1)
      begin
        d = rdata;
        r = rresp;
        break;
      end
    end
    rready <= 1'b0;
    if (n == 50)
    begin
      errors++;
      end_of_test();
    end
    @(posedge clk_sys_i);
  endtask : rdr

  // Natural channel index source*4+channel for a vector bit
  function automatic int nat(input int i);
    if (i < 4) return 4 + i;
    if (i < 8) return i - 4;
    if (i < 12) return 19 - i;
    return 27 - i;
  endfunction : nat

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    cyc(20);
    reset_i <= 1'b0;
    cyc(1);
    rdr(`SWCD_OFS_RX_SET, rd, resp);
    check("rx_set reset", rd, 32'h0000_0001);
    rdr(`SWCD_OFS_PT_LO, rd, resp);
    check("pulse reset", rd, 32'h0000_0000);
    check("term reset", {16'h0, term}, 32'h0000_ffff);
    check("aux reset", {24'h0, aux}, 32'h0000_0080);
    // Pre-emphasis codes
    for (int c = 0; c < 4; c++)
    begin
      w8(`SWCD_OFS_TX_SET, 8'(c << 2));
      cyc(2);
      check("preemph", {30'h0, pe}, 32'(c));
    end
    // Auxiliary routing in both bundling modes
    for (int c = 0; c < 32; c++)
    begin
      w8(`SWCD_OFS_AUX_CTL, 8'(c));
      cyc(2);
      check("aux mode", {31'h0, single}, 32'(c >> 4));
      if (c < 16)
        check("aux dual", {24'h0, aux}, 32'({4'(8 + (c & 4) * 1 + (c & 3)),
                                             4'((c & 4) + (c & 3))}));
      else
        check("aux single", {24'h0, aux}, 32'({4'(c), 4'(c)}));
    end
    // Equalizer bit to channel mapping, one bit at a time
    for (int i = 0; i < 16; i++)
    begin
      w8(`SWCD_OFS_EQ_LO, 8'(i < 8 ? 1 << i : 0));
      w8(`SWCD_OFS_EQ_HI, 8'(i >= 8 ? 1 << (i - 8) : 0));
      cyc(2);
      check("eq map", {16'h0, eq}, 32'(1 << nat(i)));
    end
    // A switch with no pulse bits leaves every channel connected
    w8(`SWCD_OFS_SRC_SEL, 8'h02);
    cyc(2);
    check("no pulse", {16'h0, term}, 32'h0000_ffff);
    // Pulse on B0 (bit 0), A0 (bit 4) and C3 (bit 8) only
    w8(`SWCD_OFS_PT_LO, 8'h11);
    w8(`SWCD_OFS_PT_HI, 8'h01);
    w8(`SWCD_OFS_SRC_SEL, 8'h01);
    cyc(2);
    check("term pulsed", {16'h0, term}, 32'h0000_f7ee);
    check("hs source", {30'h0, hs_src}, 32'h0000_0001);
    rdr(`SWCD_OFS_STATUS, rd, resp);
    check("busy", {31'h0, rd[16]}, 32'h0000_0001);
    cyc(PC + 4);
    check("term back", {16'h0, term}, 32'h0000_ffff);
    // A second switch mid-interval restarts the count
    w8(`SWCD_OFS_SRC_SEL, 8'h02);
    cyc(10);
    w8(`SWCD_OFS_SRC_SEL, 8'h03);
    cyc(12);
    check("term restart", {16'h0, term}, 32'h0000_f7ee);
    cyc(PC);
    check("term end", {16'h0, term}, 32'h0000_ffff);
    w8(`SWCD_OFS_SRC_SEL, 8'h03);
    cyc(2);
    check("same source", {16'h0, term}, 32'h0000_ffff);
    // Enable cleared overrides pulse bits
    w8(`SWCD_OFS_PT_LO, 8'hff);
    w8(`SWCD_OFS_RX_SET, 8'h00);
    cyc(2);
    check("term off", {16'h0, term}, 32'h0000_0000);
    w8(`SWCD_OFS_SRC_SEL, 8'h00);
    cyc(PC + 4);
    check("term off sw", {16'h0, term}, 32'h0000_0000);
    w8(`SWCD_OFS_RX_SET, 8'h01);
    cyc(2);
    check("term on", {16'h0, term}, 32'h0000_ffff);
    // Refusal of an unmapped place; an empty strobe is answered OKAY and ignored
    wr(8'h40, 32'h0000_00ff, 4'h1, resp);
    check("unmapped b", {30'h0, resp}, {30'h0, `SWCD_RESP_SLVERR});
    rdr(8'h40, rd, resp);
    check("unmapped r", {30'h0, resp}, {30'h0, `SWCD_RESP_SLVERR});
    check("unmapped d", rd, 32'h0000_0000);
    wr(`SWCD_OFS_TX_SET, 32'h0000_0000, 4'h0, resp);
    check("no strobe b", {30'h0, resp}, {30'h0, `SWCD_RESP_OKAY});
    cyc(2);
    check("no strobe", {30'h0, pe}, 32'h0000_0003);
    end_of_test();
  end

endmodule : swcd_top_tb_top
